// ==== shared/pogc_pkg.sv ====
// Purpose: constants and carrier types of the pixel offset/gain compensation block
// Assumes: 10-bit converter samples, 16-bit per-pixel coefficient word
// Notes:   register offsets are word addresses on the plain register port
package pogc_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int PIX_W   = 10;
   localparam int COEF_W  = 16;
   localparam int GAIN_W  = 12;
   localparam int OFF_W   = 6;
   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 16;
   localparam int GAIN_SH = 11;

   // ------------------------------------------------------------
   // limits and reset values
   // ------------------------------------------------------------
   localparam logic [PIX_W-1:0]  PIX_MAX       = 10'h3FF;
   localparam logic [PIX_W-1:0]  PIX_MIN       = 10'h000;
   localparam logic [GAIN_W-1:0] GAIN_UNITY    = 12'h800;
   localparam logic [OFF_W-1:0]  OFF_RESET     = 6'h00;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_CTRL      = 4'h0;
   localparam logic [ADDR_W-1:0] REG_DEF_OFF   = 4'h1;
   localparam logic [ADDR_W-1:0] REG_DEF_GAIN  = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h3;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN    = 4'h5;

   // status bits
   localparam int ST_RANGE = 0;
   localparam int ST_PIXEL = 1;
   localparam int ST_W     = 2;

   // ------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid_bit_mode;
      logic partition_select_hi;
      logic partition_select_lo;
      logic invert_output_bit;
      logic use_ext_offset;
      logic comp_enable;
   } pogc_ctrl_t;

   localparam int CTRL_W = $bits(pogc_ctrl_t);
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

   typedef struct packed {
      logic             range;
      logic             dv;
      logic [PIX_W-1:0] value;
   } pogc_pix_t;

   typedef enum logic [2:0] {
      POGC_PART_G12_O4,
      POGC_PART_G11_O5,
      POGC_PART_G10_O6,
      POGC_PART_G11_DV_O4,
      POGC_PART_G10_DV_O5
   } pogc_part_t;

endpackage

// ==== core/pogc_top.sv ====
// Purpose: per-pixel offset add and gain multiply with saturation
// Assumes: converter samples arrive on sys_clk; coefficient pins are asynchronous
// Notes:   two pipeline stages from accepted sample to output
//
// What this block does
// - bypass forwards sample, complemented if invert set, when disabled
// - two coefficient bytes pair into one word
// - word splits into offset, gain, valid fields
// - offset from bus or default register
// - offset sum saturates to 0..1023
// - gain stage multiplies by factor 0..2
// - gain product saturates to 0..1023
// - output is (sample plus offset) times gain
// - offset is two's complement integer
// - gain unsigned, half code is unity
// - mode zero: 12 gain, 4 offset bits
// - invert bit complements converter code
// - range flag marks pixels hitting a limit
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pogc_top
   import pogc_pkg::*;
(
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          nrst,
   // register port
   input  wire logic [pogc_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [pogc_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [pogc_pkg::DATA_W-1:0]   reg_rdata,
   // converter side
   input  wire logic [pogc_pkg::PIX_W-1:0]    converter_result,
   input  wire logic                          converter_valid,
   // coefficient pins
   input  wire logic [7:0]                    coefficient_bus,
   input  wire logic                          coef_byte_strobe,
   // pixel output
   output logic      [pogc_pkg::PIX_W-1:0]    pixel_output_bus,
   output logic                               out_of_range_flag,
   output logic                               pixel_data_valid,
   output logic                               pixel_out_strobe,
   output logic                               irq
);
   import pogc_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   pogc_ctrl_t           ctrl_q;
   logic [OFF_W-1:0]     def_off_q;
   logic [GAIN_W-1:0]    def_gain_q;
   logic [ST_W-1:0]      status_q;
   logic [ST_W-1:0]      irq_en_q;
   logic [ST_W-1:0]      ev_d;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q     <= CTRL_RESET;
         def_off_q  <= OFF_RESET;
         def_gain_q <= GAIN_UNITY;
         irq_en_q   <= '0;
      end
      else if (reg_wr)
      begin
         if (reg_addr == REG_CTRL)
            ctrl_q <= pogc_ctrl_t'(reg_wdata[CTRL_W-1:0]);
         else if (reg_addr == REG_DEF_OFF)
            def_off_q <= reg_wdata[OFF_W-1:0];
         else if (reg_addr == REG_DEF_GAIN)
            def_gain_q <= reg_wdata[GAIN_W-1:0];
         else if (reg_addr == REG_IRQ_EN)
            irq_en_q <= reg_wdata[ST_W-1:0];
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         status_q <= '0;
      else if (reg_wr && reg_addr == REG_IRQ_CLR)
         status_q <= (status_q & ~reg_wdata[ST_W-1:0]) | ev_d;
      else
         status_q <= status_q | ev_d;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         irq <= 1'b0;
      else
         irq <= |((status_q | ev_d) & irq_en_q);
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         reg_rdata <= '0;
      else if (!reg_rd)
         reg_rdata <= '0;
      else if (reg_addr == REG_CTRL)
         reg_rdata <= DATA_W'(ctrl_q);
      else if (reg_addr == REG_DEF_OFF)
         reg_rdata <= DATA_W'(def_off_q);
      else if (reg_addr == REG_DEF_GAIN)
         reg_rdata <= DATA_W'(def_gain_q);
      else if (reg_addr == REG_STATUS)
         reg_rdata <= DATA_W'(status_q);
      else if (reg_addr == REG_IRQ_EN)
         reg_rdata <= DATA_W'(irq_en_q);
      else
         reg_rdata <= '0;
   end

   // ------------------------------------------------------------
   // coefficient pin synchroniser and byte pairing
   // ------------------------------------------------------------
   logic [8:0]           pin_s1_q;
   logic [8:0]           pin_s2_q;
   logic                 phase_q;
   logic [7:0]           first_byte_q;
   logic [COEF_W-1:0]    coef_word_q;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end
      else
      begin
         pin_s1_q <= {coef_byte_strobe, coefficient_bus};
         pin_s2_q <= pin_s1_q;
      end
   end

   // first byte is the high half of the word
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         phase_q      <= 1'b0;
         first_byte_q <= '0;
         coef_word_q  <= {GAIN_UNITY, 4'h0};
      end
      else if (converter_valid)
         phase_q <= 1'b0;
      else if (pin_s2_q[8])
      begin
         phase_q <= ~phase_q;
         if (!phase_q)
            first_byte_q <= pin_s2_q[7:0];
         else
            coef_word_q <= {first_byte_q, pin_s2_q[7:0]};
      end
   end

   // ------------------------------------------------------------
   // partitioning
   // ------------------------------------------------------------
   pogc_part_t           part;
   logic [GAIN_W-1:0]    ext_gain;
   logic signed [OFF_W-1:0] ext_off;
   logic                 ext_dv;

   always_comb
   begin
      if (ctrl_q.valid_bit_mode)
         part = ctrl_q.partition_select_lo ? POGC_PART_G10_DV_O5 : POGC_PART_G11_DV_O4;
      else if (ctrl_q.partition_select_hi)
         part = POGC_PART_G10_O6;
      else if (ctrl_q.partition_select_lo)
         part = POGC_PART_G11_O5;
      else
         part = POGC_PART_G12_O4;
   end

   // gain is left aligned to 12 bits so half code always means unity
   always_comb
   begin
      ext_dv = 1'b1;
      case (part)
         POGC_PART_G11_O5:
         begin
            ext_gain = {coef_word_q[15:5], 1'b0};
            ext_off  = OFF_W'(signed'(coef_word_q[4:0]));
         end
         POGC_PART_G10_O6:
         begin
            ext_gain = {coef_word_q[15:6], 2'h0};
            ext_off  = signed'(coef_word_q[5:0]);
         end
         POGC_PART_G11_DV_O4:
         begin
            ext_gain = {coef_word_q[15:5], 1'b0};
            ext_dv   = coef_word_q[4];
            ext_off  = OFF_W'(signed'(coef_word_q[3:0]));
         end
         POGC_PART_G10_DV_O5:
         begin
            ext_gain = {coef_word_q[15:6], 2'h0};
            ext_dv   = coef_word_q[5];
            ext_off  = OFF_W'(signed'(coef_word_q[4:0]));
         end
         default:
         begin
            ext_gain = coef_word_q[15:4];
            ext_off  = OFF_W'(signed'(coef_word_q[3:0]));
         end
      endcase
   end

   // ------------------------------------------------------------
   // offset stage
   // ------------------------------------------------------------
   logic [PIX_W-1:0]        sample;
   logic signed [OFF_W-1:0] off_sel;
   logic signed [PIX_W+1:0] sum;
   logic [PIX_W-1:0]        s1_val_q;
   logic [GAIN_W-1:0]       s1_gain_q;
   logic                    s1_rng_q;
   logic                    s1_dv_q;
   logic                    s1_comp_q;
   logic                    s1_vld_q;

   assign sample  = ctrl_q.invert_output_bit ? ~converter_result : converter_result;
   assign off_sel = ctrl_q.use_ext_offset ? ext_off : signed'(def_off_q);
   assign sum     = signed'({2'b00, sample}) + (PIX_W+2)'(off_sel);

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_val_q  <= '0;
         s1_gain_q <= GAIN_UNITY;
         s1_rng_q  <= 1'b0;
         s1_dv_q   <= 1'b1;
         s1_comp_q <= 1'b0;
         s1_vld_q  <= 1'b0;
      end
      else
      begin
         s1_vld_q <= converter_valid;
         if (converter_valid)
         begin
            s1_comp_q <= ctrl_q.comp_enable;
            s1_gain_q <= ctrl_q.use_ext_offset ? ext_gain : def_gain_q;
            s1_dv_q   <= ctrl_q.use_ext_offset ? ext_dv : 1'b1;
            if (!ctrl_q.comp_enable)
            begin
               s1_val_q <= sample;
               s1_rng_q <= 1'b0;
            end
            else if (sum < 0)
            begin
               s1_val_q <= PIX_MIN;
               s1_rng_q <= 1'b1;
            end
            else if (sum > signed'({2'b00, PIX_MAX}))
            begin
               s1_val_q <= PIX_MAX;
               s1_rng_q <= 1'b1;
            end
            else
            begin
               s1_val_q <= sum[PIX_W-1:0];
               s1_rng_q <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // gain stage
   // ------------------------------------------------------------
   logic [PIX_W+GAIN_W-1:0] prod;
   logic [PIX_W+GAIN_W-1:0] scaled;
   pogc_pix_t               out_d;

   assign prod   = (PIX_W+GAIN_W)'(s1_val_q) * (PIX_W+GAIN_W)'(s1_gain_q);
   assign scaled = prod >> GAIN_SH;

   always_comb
   begin
      out_d.dv = s1_dv_q;
      if (!s1_comp_q)
      begin
         out_d.value = s1_val_q;
         out_d.range = 1'b0;
      end
      else if (prod > ((PIX_W+GAIN_W)'(PIX_MAX) << GAIN_SH))
      begin
         out_d.value = PIX_MAX;
         out_d.range = 1'b1;
      end
      else
      begin
         out_d.value = scaled[PIX_W-1:0];
         out_d.range = s1_rng_q;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pixel_output_bus  <= '0;
         out_of_range_flag <= 1'b0;
         pixel_data_valid  <= 1'b0;
         pixel_out_strobe  <= 1'b0;
      end
      else
      begin
         pixel_out_strobe <= s1_vld_q;
         if (s1_vld_q)
         begin
            pixel_output_bus  <= out_d.value;
            out_of_range_flag <= out_d.range;
            pixel_data_valid  <= out_d.dv;
         end
      end
   end

   assign ev_d[ST_RANGE] = s1_vld_q & out_d.range;
   assign ev_d[ST_PIXEL] = s1_vld_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence seq_byte_pair;
      pin_s2_q[8] && !phase_q && !converter_valid ##1 pin_s2_q[8] && phase_q && !converter_valid;
   endsequence

   chk_bypass_pass: assert property (converter_valid && !ctrl_q.comp_enable && !ctrl_q.invert_output_bit
      |-> ##2 pixel_output_bus == $past(converter_result, 2) && !out_of_range_flag)
      else $error("bypass sample altered");
   chk_pair_word: assert property (seq_byte_pair
      |=> coef_word_q == {$past(pin_s2_q[7:0], 2), $past(pin_s2_q[7:0])})
      else $error("coefficient pair wrong");
   chk_part_zero: assert property (part == POGC_PART_G12_O4 && ctrl_q.use_ext_offset && converter_valid
      |=> s1_gain_q == $past(coef_word_q[15:4]))
      else $error("mode zero gain field wrong");
   chk_offset_source: assert property (!ctrl_q.use_ext_offset |-> off_sel == signed'(def_off_q))
      else $error("offset source wrong");
   chk_offset_floor: assert property (converter_valid && ctrl_q.comp_enable && sum < 0
      |=> s1_val_q == PIX_MIN && s1_rng_q ##1 out_of_range_flag && pixel_output_bus == PIX_MIN)
      else $error("offset floor not applied");
   chk_gain_unity: assert property (s1_vld_q && s1_comp_q && s1_gain_q == GAIN_UNITY
      |=> pixel_output_bus == $past(s1_val_q))
      else $error("unity gain changed value");
   chk_gain_ceiling: assert property (s1_vld_q && s1_comp_q && prod > ((PIX_W+GAIN_W)'(PIX_MAX) << GAIN_SH)
      |=> pixel_output_bus == PIX_MAX && out_of_range_flag)
      else $error("gain ceiling not applied");
   chk_invert_code: assert property (converter_valid && !ctrl_q.comp_enable && ctrl_q.invert_output_bit
      |-> ##2 pixel_output_bus == ~$past(converter_result, 2))
      else $error("inverted code wrong");
   chk_irq_level: assert property (##1 irq == |(($past(status_q) | $past(ev_d)) & $past(irq_en_q)))
      else $error("interrupt level wrong");

endmodule

`default_nettype wire

// ==== test/pogc_coef_ram.sv ====
// Purpose: coefficient memory model driving the coefficient byte pins
// Assumes: one word request at a time, taken on go
// Notes:   pins carry a changing pattern while no byte is presented
`timescale 1ns/1ps
`default_nettype none

module pogc_coef_ram
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // request side
   input  wire logic        go,
   input  wire logic [15:0] word,
   input  wire logic [1:0]  slow,
   output logic             busy,
   // coefficient pins
   output logic [7:0]       coefficient_bus,
   output logic             coef_byte_strobe
);
   // ----------------------------------------------------------
   // byte sequencer
   // ----------------------------------------------------------
   logic       st_q;
   logic [1:0] gap_q;
   logic [7:0] lo_q;

   assign busy = st_q;

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q             <= 1'b0;
         gap_q            <= 2'h0;
         lo_q             <= 8'h00;
         coefficient_bus  <= 8'h00;
         coef_byte_strobe <= 1'b0;
      end
      else if (!st_q && go)
      begin
         coefficient_bus  <= word[15:8];
         lo_q             <= word[7:0];
         gap_q            <= slow;
         coef_byte_strobe <= 1'b1;
         st_q             <= 1'b1;
      end
      else if (st_q && gap_q == 2'h0)
      begin
         coefficient_bus  <= lo_q;
         coef_byte_strobe <= 1'b1;
         st_q             <= 1'b0;
      end
      else
      begin
         coefficient_bus  <= ~coefficient_bus;
         coef_byte_strobe <= 1'b0;
         gap_q            <= gap_q - 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Purpose: self-checking bench of the compensation block
// Assumes: coefficient word complete before each sample
// Notes:   random configs with table corners among them
`timescale 1ns/1ps
`default_nettype none

module tb;
   import pogc_pkg::*;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   logic              sys_clk, nrst, reg_wr, reg_rd, converter_valid;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [PIX_W-1:0]  converter_result, pixel_output_bus;
   logic [7:0]        coefficient_bus;
   logic              coef_byte_strobe, out_of_range_flag, pixel_data_valid, pixel_out_strobe, irq;
   logic              go, busy;
   logic [15:0]       word;
   logic [1:0]        slow;
   int                mismatches = 0;
   int                num_checks = 0;
   int                cycles = 0;
   pogc_ctrl_t        c_v;
   logic [5:0]        doff_v;
   logic [11:0]       dg_v;
   int                ex_x[9] = '{512, 512, 512, 1022, 1022, 512, 512, 512, 511};
   int                ex_o[9] = '{0, -7, 6, 6, 6, 0, 0, 0, 0};
   int                ex_g[9] = '{2048, 2048, 2048, 2048, 512, 2560, 512, 4095, 4095};
   int                ex_p[9] = '{512, 505, 518, 1023, 255, 640, 128, 1023, 1021};
   int                ex_f[9] = '{0, 0, 0, 1, 1, 0, 0, 1, 0};

   pogc_top DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .converter_result(converter_result),
      .converter_valid(converter_valid), .coefficient_bus(coefficient_bus),
      .coef_byte_strobe(coef_byte_strobe), .pixel_output_bus(pixel_output_bus),
      .out_of_range_flag(out_of_range_flag), .pixel_data_valid(pixel_data_valid),
      .pixel_out_strobe(pixel_out_strobe), .irq(irq));

   pogc_coef_ram ram (.sys_clk(sys_clk), .nrst(nrst), .go(go), .word(word), .slow(slow), .busy(busy),
      .coefficient_bus(coefficient_bus), .coef_byte_strobe(coef_byte_strobe));

   always #50 sys_clk = ~sys_clk;

   // ----------------------------------------------------------
   // expected pixel: {valid, flag, value}
   // ----------------------------------------------------------
   function automatic logic [11:0] model(pogc_ctrl_t c, logic [15:0] w, logic [5:0] d, logic [11:0] dg,
                                         logic [9:0] x);
      int   s, o, g, p;
      logic f, dv;
      s = c.invert_output_bit ? 1023 - x : x;
      f = 1'b0;
      dv = 1'b1;
      g = dg;
      o = $signed(d);
      if (c.use_ext_offset)
      begin
         case ({c.valid_bit_mode, c.partition_select_hi, c.partition_select_lo})
            3'h0: begin g = w[15:4]; o = $signed(w[3:0]); end
            3'h1: begin g = w[15:5] << 1; o = $signed(w[4:0]); end
            3'h2: begin g = w[15:6] << 2; o = $signed(w[5:0]); end
            3'h4: begin g = w[15:5] << 1; dv = w[4]; o = $signed(w[3:0]); end
            default: begin g = w[15:6] << 2; dv = w[5]; o = $signed(w[4:0]); end
         endcase
      end
      if (!c.comp_enable)
         return {dv, f, 10'(s)};
      s = s + o;
      if (s < 0 || s > 1023)
         f = 1'b1;
      s = (s < 0) ? 0 : (s > 1023) ? 1023 : s;
      p = (s * g) >> 11;
      if (s * g > (1023 << GAIN_SH))
         f = 1'b1;
      p = (p > 1023) ? 1023 : p;
      return {dv, f, 10'(p)};
   endfunction

   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(logic [3:0] a, logic [15:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask

   task automatic cfg(pogc_ctrl_t c, logic [15:0] o, logic [15:0] g);
      c_v = c;
      doff_v = o[5:0];
      dg_v = g[11:0];
      wr(REG_CTRL, 16'(c));
      wr(REG_DEF_OFF, o);
      wr(REG_DEF_GAIN, g);
      rd(REG_DEF_OFF, {10'h000, o[5:0]});
      rd(REG_DEF_GAIN, {4'h0, g[11:0]});
   endtask

   task automatic pix(logic [9:0] x, logic [15:0] w, logic [1:0] sl);
      logic [11:0] e;
      int          n;
      e = model(c_v, w, doff_v, dg_v, x);
      n = 0;
      @(posedge sys_clk);
      word <= w;
      slow <= sl;
      go   <= 1'b1;
      @(posedge sys_clk);
      go   <= 1'b0;
      do
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      while (busy && n < 20);
      repeat (4) @(posedge sys_clk);
      converter_result <= x;
      converter_valid  <= 1'b1;
      @(posedge sys_clk);
      converter_valid  <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("pixel_out_strobe", 16'h0001, pixel_out_strobe);
      chk("pixel_output_bus", e[9:0], pixel_output_bus);
      chk("out_of_range_flag", e[10], out_of_range_flag);
      chk("pixel_data_valid", e[11], pixel_data_valid);
   endtask

   task automatic wrap_up;
      if (mismatches == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      pogc_ctrl_t c;
      void'($urandom(3706));
      sys_clk = 1'b0;
      nrst = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      converter_result = 10'h000;
      converter_valid = 1'b0;
      go = 1'b0;
      word = 16'h0000;
      slow = 2'h0;
      repeat (10) @(posedge sys_clk);
      chk("pixel_output_bus", 16'h0000, pixel_output_bus);
      nrst <= 1'b1;
      rd(REG_CTRL, 16'h0000);
      rd(REG_DEF_OFF, 16'h0000);
      rd(REG_DEF_GAIN, 16'h0800);
      rd(4'hF, 16'h0000);
      rd(REG_IRQ_CLR, 16'h0000);
      c = '0;
      c.comp_enable = 1'b1;
      c.use_ext_offset = 1'b1;
      cfg(c, 16'h0000, 16'h0800);
      for (int i = 0; i < 9; i++)
      begin
         pix(10'(ex_x[i]), {ex_g[i][11:0], ex_o[i][3:0]}, 2'(i));
         chk("table_pixel", 16'(ex_p[i]), pixel_output_bus);
         chk("table_range", 16'(ex_f[i]), out_of_range_flag);
      end
      c.invert_output_bit = 1'b1;
      pix(10'h3FF, 16'h800F, 2'h0);
      c.comp_enable = 1'b0;
      cfg(c, 16'h0000, 16'h0800);
      pix(10'h000, 16'hFFFF, 2'h3);
      for (int i = 0; i < 80; i++)
      begin
         c = pogc_ctrl_t'(6'($urandom));
         if (c.partition_select_hi)
            c.partition_select_lo = 1'b0;
         if (c.partition_select_hi)
            c.valid_bit_mode = 1'b0;
         if (c.valid_bit_mode)
            c.use_ext_offset = 1'b1;
         cfg(c, 16'($urandom), 16'($urandom));
         pix(10'($urandom), 16'($urandom), 2'($urandom));
      end
      wr(REG_IRQ_CLR, 16'h0003);
      c = '0;
      c.comp_enable = 1'b1;
      c.use_ext_offset = 1'b1;
      cfg(c, 16'h0000, 16'h0800);
      pix(10'h3FE, 16'h8006, 2'h1);
      wr(REG_STATUS, 16'h0000);
      rd(REG_STATUS, 16'h0003);
      chk("irq", 16'h0000, irq);
      wr(REG_IRQ_EN, 16'h0001);
      rd(REG_IRQ_EN, 16'h0001);
      chk("irq", 16'h0001, irq);
      wr(REG_IRQ_CLR, 16'h0001);
      rd(REG_STATUS, 16'h0002);
      chk("irq", 16'h0000, irq);
      wrap_up();
   end
endmodule
`default_nettype wire
